// *** include/mrcr_pkg.sv ***
package mrcr_pkg;
  // Register offsets (byte addresses)
  localparam logic [11:0] MRCR_MASTER_RESET_REVISION_OFS = 12'h000;
  localparam logic [11:0] MRCR_MASTER_CONFIGURATION_OFS  = 12'h010;
  // Reset values
  localparam logic [15:0] MRCR_REG_RESET_VAL = 16'h0000;
  // Reset/revision fields
  localparam int MRCR_SOFT_RESET_BIT = 0;
  localparam int MRCR_REV_LSB        = 8;
  // Master configuration fields
  localparam int MRCR_RX_DMA_EN_BIT    = 0;
  localparam int MRCR_RX_BURST_LSB     = 1;
  localparam int MRCR_TX_DMA_EN_BIT    = 3;
  localparam int MRCR_TX_BURST_LSB     = 4;
  localparam int MRCR_BYTE_ORDER_BIT   = 6;
  localparam int MRCR_TESTER_PORT_LSB  = 7;
  localparam int MRCR_RX_ARB_LSB       = 12;
  localparam int MRCR_TX_ARB_LSB       = 14;
  // Burst caps in dwords, indexed by the 2-bit limit code
  localparam logic [8:0] MRCR_BURST_32  = 9'h020;
  localparam logic [8:0] MRCR_BURST_64  = 9'h040;
  localparam logic [8:0] MRCR_BURST_128 = 9'h080;
  localparam logic [8:0] MRCR_BURST_256 = 9'h100;
  // Tester port codes
  localparam logic [4:0] MRCR_PORT_LAST_LOW = 5'h0f;
  localparam logic [4:0] MRCR_PORT_HS0      = 5'h10;
  localparam logic [4:0] MRCR_PORT_HS1      = 5'h11;
  // Arbitration modes
  typedef enum logic [1:0] {
    MRCR_ARB_ROUND_ROBIN = 2'b00,
    MRCR_ARB_FIXED_2     = 2'b01,
    MRCR_ARB_FIXED_16    = 2'b10,
    MRCR_ARB_FIXED_64    = 2'b11
  } mrcr_arb_t;
  // Fixed priority channel counts
  localparam logic [6:0] MRCR_FIXED_NONE = 7'h00;
  localparam logic [6:0] MRCR_FIXED_2    = 7'h02;
  localparam logic [6:0] MRCR_FIXED_16   = 7'h10;
  localparam logic [6:0] MRCR_FIXED_64   = 7'h40;
endpackage

// *** src/mrcr_dma_decode.sv ***
`timescale 1ns/10ps
// Decodes one DMA direction's burst cap and arbitration span
module mrcr_dma_decode
  import mrcr_pkg::*;
(
  input  wire logic [1:0] BURST_CODE_I,  // Burst limit field
  input  wire logic [1:0] ARB_CODE_I,    // Arbitration field
  output logic      [8:0] BURST_MAX_O,   // Max dwords per burst
  output logic      [6:0] FIXED_CNT_O    // Channels in fixed priority
);
  // Burst cap lookup
  always_comb begin
    unique case (BURST_CODE_I)
      2'b00:   BURST_MAX_O = MRCR_BURST_32;
      2'b01:   BURST_MAX_O = MRCR_BURST_64;
      2'b10:   BURST_MAX_O = MRCR_BURST_128;
      2'b11:   BURST_MAX_O = MRCR_BURST_256;
    endcase
  end
  // Fixed priority span, lower channel wins, rest round robin
  always_comb begin
    unique case (mrcr_arb_t'(ARB_CODE_I))
      MRCR_ARB_ROUND_ROBIN: FIXED_CNT_O = MRCR_FIXED_NONE;
      MRCR_ARB_FIXED_2:     FIXED_CNT_O = MRCR_FIXED_2;
      MRCR_ARB_FIXED_16:    FIXED_CNT_O = MRCR_FIXED_16;
      MRCR_ARB_FIXED_64:    FIXED_CNT_O = MRCR_FIXED_64;
    endcase
  end
endmodule // mrcr_dma_decode

// *** src/mrcr_regs.sv ***
`timescale 1ns/10ps
// Limitation: a configuration write while the soft reset bit is set
// is lost, so software clears that bit before configuring.
module mrcr_regs
  import mrcr_pkg::*;
#(
  parameter logic [7:0] CHIP_REVISION = 8'h01, // Arbitrary value
  parameter int         BRIDGE_W      = 16     // Bridge mode control width
)(
  input  wire logic                REF_CLK_I,        // System clock
  input  wire logic                RESET_I,          // Hardware bus reset
  input  wire logic                REG_WR_I,         // Register write strobe
  input  wire logic                REG_RD_I,         // Register read strobe
  input  wire logic [11:0]         REG_ADDR_I,       // Register byte address
  input  wire logic [15:0]         REG_WDATA_I,      // Write data
  output logic      [15:0]         REG_RDATA_O,      // Read data
  input  wire logic                BRIDGE_WR_I,      // Bridge mode write strobe
  input  wire logic [BRIDGE_W-1:0] BRIDGE_WDATA_I,   // Bridge mode write data
  output logic      [BRIDGE_W-1:0] BRIDGE_MODE_O,    // Bridge mode control
  input  wire logic [31:0]         PKT_DATA_I,       // Packet word, internal order
  output logic      [31:0]         PKT_BUS_DATA_O,   // Packet word, bus order
  output logic                     SOFT_RESET_O,     // Soft reset active
  output logic                     BUS_OUT_EN_N_O,   // Bus driver enable, low drives
  output logic                     RX_DMA_EN_O,      // Receive DMA may move data
  output logic                     TX_DMA_EN_O,      // Transmit DMA may move data
  output logic      [8:0]          RX_BURST_MAX_O,   // Receive burst cap, dwords
  output logic      [8:0]          TX_BURST_MAX_O,   // Transmit burst cap, dwords
  output logic                     BIG_ENDIAN_O,     // Packet byte order
  output logic      [4:0]          TESTER_PORT_O,    // Tester port code
  output logic                     TESTER_HI_SPEED_O,// Tester on high-speed port
  output logic                     TESTER_VALID_O,   // Tester code is usable
  output logic      [1:0]          RX_ARB_MODE_O,    // Receive arbitration mode
  output logic      [1:0]          TX_ARB_MODE_O,    // Transmit arbitration mode
  output logic      [6:0]          RX_FIXED_CNT_O,   // Receive fixed-priority span
  output logic      [6:0]          TX_FIXED_CNT_O    // Transmit fixed-priority span
);

  // Register state and next values
  logic                soft_reset_r;    // Software reset bit
  logic                soft_reset_nxt;  // Next soft reset
  logic [15:0]         config_r;        // Master configuration word
  logic [15:0]         config_nxt;      // Next configuration
  logic [BRIDGE_W-1:0] bridge_r;        // Bridge mode control
  logic [BRIDGE_W-1:0] bridge_nxt;      // Next bridge mode
  logic [15:0]         rdata_r;         // Registered read data
  logic [15:0]         rdata_nxt;       // Next read data
  logic [31:0]         pkt_r;           // Registered packet word
  logic [31:0]         pkt_nxt;         // Next packet word

  // Address and strobe decode
  logic                sel_rst;         // Reset/revision selected
  logic                sel_cfg;         // Configuration selected
  logic                rst_wr;          // Write to reset/revision
  logic                cfg_wr;          // Write to configuration
  logic                rst_rd;          // Read of reset/revision
  logic                cfg_rd;          // Read of configuration

  // Configuration field views
  logic [1:0]          rx_burst_code;   // Receive burst limit field
  logic [1:0]          tx_burst_code;   // Transmit burst limit field
  logic [1:0]          rx_arb_code;     // Receive arbitration field
  logic [1:0]          tx_arb_code;     // Transmit arbitration field
  logic [4:0]          tester_code;     // Tester port field
  logic                pkt_big;         // Packet words byte-reversed

  // Address decode, full byte address compared
  assign sel_rst = (REG_ADDR_I == MRCR_MASTER_RESET_REVISION_OFS);
  assign sel_cfg = (REG_ADDR_I == MRCR_MASTER_CONFIGURATION_OFS);

  // Qualified strobes, unmapped addresses fall through
  assign rst_wr = REG_WR_I && sel_rst;
  assign cfg_wr = REG_WR_I && sel_cfg;
  assign rst_rd = REG_RD_I && sel_rst;
  assign cfg_rd = REG_RD_I && sel_cfg;

  // Field views of the configuration word
  assign rx_burst_code = config_r[MRCR_RX_BURST_LSB +: 2];
  assign tx_burst_code = config_r[MRCR_TX_BURST_LSB +: 2];
  assign rx_arb_code   = config_r[MRCR_RX_ARB_LSB +: 2];
  assign tx_arb_code   = config_r[MRCR_TX_ARB_LSB +: 2];
  assign tester_code   = config_r[MRCR_TESTER_PORT_LSB +: 5];
  assign pkt_big       = config_r[MRCR_BYTE_ORDER_BIT];

  // Next values of the control registers
  always_comb begin
    soft_reset_nxt = soft_reset_r;
    config_nxt     = config_r;
    bridge_nxt     = bridge_r;
    // Only the low bit of that word is storage, the rest is ignored
    if (rst_wr) begin
      soft_reset_nxt = REG_WDATA_I[MRCR_SOFT_RESET_BIT];
    end
    // Host word taken as is, register order is fixed
    if (cfg_wr) begin
      config_nxt = REG_WDATA_I;
    end
    // Soft reset wins over a write in the same cycle
    if (soft_reset_r) begin
      config_nxt = MRCR_REG_RESET_VAL;
    end
    // Bridge mode has its own strobe, soft reset leaves it alone
    if (BRIDGE_WR_I) begin
      bridge_nxt = BRIDGE_WDATA_I;
    end
  end

  // Control registers, only the hardware reset clears them all
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      // The pin clears the soft reset bit too
      soft_reset_r <= 1'b0;
      config_r     <= MRCR_REG_RESET_VAL;
      bridge_r     <= '0;
    end else begin
      // Normal update from the next-value logic
      soft_reset_r <= soft_reset_nxt;
      config_r     <= config_nxt;
      bridge_r     <= bridge_nxt;
    end
  end

  // Next read data, zero when idle or unmapped
  always_comb begin
    rdata_nxt = MRCR_REG_RESET_VAL;
    if (rst_rd) begin
      // Revision byte above, reserved bits read zero
      rdata_nxt = {CHIP_REVISION, 7'h00, soft_reset_r};
    end else if (cfg_rd) begin
      // Register reads stay little-endian
      rdata_nxt = config_r;
    end
  end

  // Read data register, stands one cycle after the strobe
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      // Bus sees zero until the first read
      rdata_r <= MRCR_REG_RESET_VAL;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Next packet word, byte steering by the order bit
  always_comb begin
    if (pkt_big) begin
      // Low byte goes to the highest byte lane
      pkt_nxt = {PKT_DATA_I[7:0], PKT_DATA_I[15:8],
                 PKT_DATA_I[23:16], PKT_DATA_I[31:24]};
    end else begin
      // Low byte stays in the lowest byte lane
      pkt_nxt = PKT_DATA_I;
    end
  end

  // Packet word register, one cycle of latency
  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      // Packet pipe empties on hardware reset
      pkt_r <= '0;
    end else begin
      pkt_r <= pkt_nxt;
    end
  end

  // Receive side decode
  mrcr_dma_decode u_rx_decode (
    .BURST_CODE_I (rx_burst_code),
    .ARB_CODE_I   (rx_arb_code),
    .BURST_MAX_O  (RX_BURST_MAX_O),
    .FIXED_CNT_O  (RX_FIXED_CNT_O)
  );

  // Transmit side decode
  mrcr_dma_decode u_tx_decode (
    .BURST_CODE_I (tx_burst_code),
    .ARB_CODE_I   (tx_arb_code),
    .BURST_MAX_O  (TX_BURST_MAX_O),
    .FIXED_CNT_O  (TX_FIXED_CNT_O)
  );

  // Register and packet outputs straight from flip-flops
  assign REG_RDATA_O       = rdata_r;
  assign PKT_BUS_DATA_O    = pkt_r;
  assign BRIDGE_MODE_O     = bridge_r;
  // Soft reset level for the rest of the chip
  assign SOFT_RESET_O      = soft_reset_r;
  // Only the hardware reset releases the bus drivers
  assign BUS_OUT_EN_N_O    = RESET_I;
  // DMA gates, each enable covers one direction only, the packet word pipe runs either way
  assign RX_DMA_EN_O       = config_r[MRCR_RX_DMA_EN_BIT];
  assign TX_DMA_EN_O       = config_r[MRCR_TX_DMA_EN_BIT];
  assign BIG_ENDIAN_O      = pkt_big;
  // Tester port, codes above the high-speed pair are unused
  assign TESTER_PORT_O     = tester_code;
  assign TESTER_HI_SPEED_O = (tester_code == MRCR_PORT_HS0) ||
                             (tester_code == MRCR_PORT_HS1);
  assign TESTER_VALID_O    = (tester_code <= MRCR_PORT_LAST_LOW) ||
                             TESTER_HI_SPEED_O;
  // Arbitration modes passed to the FIFO schedulers
  assign RX_ARB_MODE_O     = rx_arb_code;
  assign TX_ARB_MODE_O     = tx_arb_code;
endmodule // mrcr_regs

// *** testbench/mrcr_regs_checker.sv ***
`timescale 1ns/10ps
// Ties register bank outputs to host writes, reads and resets
module mrcr_regs_checker
  import mrcr_pkg::*;
#(
  parameter logic [7:0] CHIP_REVISION = 8'h01 // Arbitrary value
)(
  input wire logic        REF_CLK_I,
  input wire logic        RESET_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic [31:0] PKT_DATA_I,
  input wire logic [31:0] PKT_BUS_DATA_O,
  input wire logic        SOFT_RESET_O,
  input wire logic        BUS_OUT_EN_N_O,
  input wire logic        RX_DMA_EN_O,
  input wire logic        TX_DMA_EN_O,
  input wire logic [8:0]  RX_BURST_MAX_O,
  input wire logic        BIG_ENDIAN_O,
  input wire logic [4:0]  TESTER_PORT_O,
  input wire logic        TESTER_VALID_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // Configuration write that is not swallowed by soft reset
  wire cfg_wr = REG_WR_I && REG_ADDR_I == MRCR_MASTER_CONFIGURATION_OFS && !SOFT_RESET_O;
  wire rev_rd = REG_RD_I && REG_ADDR_I == MRCR_MASTER_RESET_REVISION_OFS;
  // Packet word in reversed byte order
  wire [31:0] swp = {PKT_DATA_I[7:0], PKT_DATA_I[15:8], PKT_DATA_I[23:16], PKT_DATA_I[31:24]};
  property p_cfg_wr;
    cfg_wr |=> {BIG_ENDIAN_O, TX_DMA_EN_O, RX_DMA_EN_O, TESTER_PORT_O} == {$past(REG_WDATA_I[6]),
      $past(REG_WDATA_I[3]), $past(REG_WDATA_I[0]), $past(REG_WDATA_I[11:7])};
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");
  property p_burst;
    cfg_wr |=> RX_BURST_MAX_O == (9'h020 << $past(REG_WDATA_I[2:1]));
  endproperty
  a_burst: assert property (p_burst) else $error("burst cap wrong");
  property p_soft;
    SOFT_RESET_O |=> !RX_DMA_EN_O && !TX_DMA_EN_O && !BIG_ENDIAN_O && TESTER_PORT_O == 5'h00;
  endproperty
  a_soft: assert property (p_soft) else $error("config kept in soft reset");
  property p_drv;
    SOFT_RESET_O |-> !BUS_OUT_EN_N_O;
  endproperty
  a_drv: assert property (p_drv) else $error("bus released by soft reset");
  property p_hw;
    $fell(RESET_I) |-> !SOFT_RESET_O && !RX_DMA_EN_O && !TX_DMA_EN_O && REG_RDATA_O == 16'h0000;
  endproperty
  a_hw: assert property (p_hw) else $error("state after reset not zero");
  property p_rev;
    rev_rd |=> REG_RDATA_O == {CHIP_REVISION, 7'h00, $past(SOFT_RESET_O)};
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");
  property p_swap;
    1'b1 |=> PKT_BUS_DATA_O == ($past(BIG_ENDIAN_O) ? $past(swp) : $past(PKT_DATA_I));
  endproperty
  a_swap: assert property (p_swap) else $error("packet byte order wrong");
  property p_tester;
    TESTER_VALID_O == (TESTER_PORT_O <= MRCR_PORT_HS1);
  endproperty
  a_tester: assert property (p_tester) else $error("tester code flag wrong");
  // Main scenarios
  c_big: cover property (cfg_wr && REG_WDATA_I[6]);
  c_lost: cover property (SOFT_RESET_O && REG_WR_I);
  c_rev: cover property (rev_rd && SOFT_RESET_O);
endmodule // mrcr_regs_checker
bind mrcr_regs mrcr_regs_checker #(.CHIP_REVISION(CHIP_REVISION)) mrcr_regs_checker_inst (
  .REF_CLK_I, .RESET_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O,
  .PKT_DATA_I, .PKT_BUS_DATA_O, .SOFT_RESET_O, .BUS_OUT_EN_N_O, .RX_DMA_EN_O, .TX_DMA_EN_O,
  .RX_BURST_MAX_O, .BIG_ENDIAN_O, .TESTER_PORT_O, .TESTER_VALID_O
);

// *** testbench/mrcr_regs_test.sv ***
`timescale 1ns/10ps
// Random host traffic with corner cases against the register bank
module mrcr_regs_test;
  import mrcr_pkg::*;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary value
  logic        REF_CLK_I, RESET_I, REG_WR_I, REG_RD_I, BRIDGE_WR_I, SOFT_RESET_O;
  logic        BUS_OUT_EN_N_O, RX_DMA_EN_O, TX_DMA_EN_O, BIG_ENDIAN_O;
  logic        TESTER_HI_SPEED_O, TESTER_VALID_O;
  logic [11:0] REG_ADDR_I;
  logic [15:0] REG_WDATA_I, REG_RDATA_O, BRIDGE_WDATA_I, BRIDGE_MODE_O, w, rdv;
  logic [31:0] PKT_DATA_I, PKT_BUS_DATA_O, p, e;
  logic [8:0]  RX_BURST_MAX_O, TX_BURST_MAX_O;
  logic [4:0]  TESTER_PORT_O, t;
  logic [1:0]  RX_ARB_MODE_O, TX_ARB_MODE_O;
  logic [6:0]  RX_FIXED_CNT_O, TX_FIXED_CNT_O;
  int          num_errors, total_checks;
  mrcr_regs #(.CHIP_REVISION(REV)) mrcr_regs_inst (
    .REF_CLK_I, .RESET_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O,
    .BRIDGE_WR_I, .BRIDGE_WDATA_I, .BRIDGE_MODE_O, .PKT_DATA_I, .PKT_BUS_DATA_O,
    .SOFT_RESET_O, .BUS_OUT_EN_N_O, .RX_DMA_EN_O, .TX_DMA_EN_O, .RX_BURST_MAX_O,
    .TX_BURST_MAX_O, .BIG_ENDIAN_O, .TESTER_PORT_O, .TESTER_HI_SPEED_O, .TESTER_VALID_O,
    .RX_ARB_MODE_O, .TX_ARB_MODE_O, .RX_FIXED_CNT_O, .TX_FIXED_CNT_O
  );
  initial begin
    REF_CLK_I = 1'b0;
    forever #2 REF_CLK_I = ~REF_CLK_I;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge REF_CLK_I) #1;
    REG_WR_I = 1'b1;
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    @(posedge REF_CLK_I) #1;
    REG_WR_I = 1'b0;
  endtask
  // One-cycle read strobe, data the cycle after
  task automatic rd(input logic [11:0] a);
    @(posedge REF_CLK_I) #1;
    REG_RD_I = 1'b1;
    REG_ADDR_I = a;
    @(posedge REF_CLK_I) #1;
    REG_RD_I = 1'b0;
    rdv = REG_RDATA_O;
  endtask
  // Fixed-priority span per arbitration code
  function automatic logic [6:0] fix(input logic [1:0] m);
    return m == 2'h0 ? MRCR_FIXED_NONE : m == 2'h1 ? MRCR_FIXED_2 :
           m == 2'h2 ? MRCR_FIXED_16 : MRCR_FIXED_64;
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
  initial begin
    RESET_I = 1'b1;
    {REG_WR_I, REG_RD_I, BRIDGE_WR_I, REG_ADDR_I, REG_WDATA_I} = '0;
    {BRIDGE_WDATA_I, PKT_DATA_I, num_errors, total_checks} = '0;
    void'($urandom(85810));
    repeat (5) @(posedge REF_CLK_I);
    #1 RESET_I = 1'b0;
    rd(MRCR_MASTER_CONFIGURATION_OFS);
    chk("cfg reset", 32'h0, rdv);
    rd(MRCR_MASTER_RESET_REVISION_OFS);
    chk("revision", {REV, 8'h00}, rdv);
    @(posedge REF_CLK_I) #1 BRIDGE_WR_I = 1'b1;
    BRIDGE_WDATA_I = 16'ha5c3;
    @(posedge REF_CLK_I) #1 BRIDGE_WR_I = 1'b0;
    // Random words, all ones and high-speed port first
    for (int i = 0; i < 24; i++) begin
      w = i == 0 ? 16'hffff : i == 1 ? 16'h08b6 : 16'($urandom);
      p = $urandom;
      PKT_DATA_I = p;
      t = w[11:7];
      wr(MRCR_MASTER_CONFIGURATION_OFS, w);
      rd(MRCR_MASTER_CONFIGURATION_OFS);
      chk("cfg read", w, rdv);
      chk("enables", {w[6], w[3], w[0]}, {BIG_ENDIAN_O, TX_DMA_EN_O, RX_DMA_EN_O});
      chk("bursts", {9'h020 << w[5:4], 9'h020 << w[2:1]}, {TX_BURST_MAX_O, RX_BURST_MAX_O});
      e = {t, t <= MRCR_PORT_HS1, t == MRCR_PORT_HS0 || t == MRCR_PORT_HS1};
      chk("tester", e, {TESTER_PORT_O, TESTER_VALID_O, TESTER_HI_SPEED_O});
      e = {w[15:12], fix(w[13:12]), fix(w[15:14])};
      chk("arb", e, {TX_ARB_MODE_O, RX_ARB_MODE_O, RX_FIXED_CNT_O, TX_FIXED_CNT_O});
      e = w[6] ? {p[7:0], p[15:8], p[23:16], p[31:24]} : p;
      chk("packet", e, PKT_BUS_DATA_O);
    end
    // Soft reset swallows a config write, spares bridge mode
    wr(MRCR_MASTER_RESET_REVISION_OFS, 16'hffff);
    wr(MRCR_MASTER_CONFIGURATION_OFS, 16'h0049);
    rd(MRCR_MASTER_RESET_REVISION_OFS);
    chk("soft read", {REV, 8'h01}, rdv);
    chk("cfg held", 32'h0, {BIG_ENDIAN_O, TX_DMA_EN_O, RX_DMA_EN_O, TESTER_PORT_O});
    chk("bridge", 32'ha5c3, BRIDGE_MODE_O);
    chk("bus drive", 32'h0, BUS_OUT_EN_N_O);
    wr(MRCR_MASTER_RESET_REVISION_OFS, 16'h0000);
    wr(MRCR_MASTER_CONFIGURATION_OFS, 16'h0036);
    wr(MRCR_MASTER_CONFIGURATION_OFS, 16'h003f);
    wr(12'h020, 16'hffff);
    rd(12'h020);
    chk("unmapped", 32'h0, rdv);
    chk("dma on", 32'h3, {TX_DMA_EN_O, RX_DMA_EN_O});
    chk("max bursts", {9'h100, 9'h100}, {TX_BURST_MAX_O, RX_BURST_MAX_O});
    // Hardware reset in mid-run
    wr(MRCR_MASTER_RESET_REVISION_OFS, 16'h0001);
    RESET_I = 1'b1;
    #1 chk("bus off", 32'h1, BUS_OUT_EN_N_O);
    @(posedge REF_CLK_I) #1 RESET_I = 1'b0;
    chk("hw reset", 32'h0, {SOFT_RESET_O, BRIDGE_MODE_O});
    rd(MRCR_MASTER_CONFIGURATION_OFS);
    chk("cfg after pin", 32'h0, rdv);
    test_done();
  end
endmodule // mrcr_regs_test
